// file: bench/rcs_contact_model.sv
`timescale 1ns/10ps
`default_nettype none
// operator switches or plc outputs: contacts change just after an edge
module rcs_contact_model (
  input  wire logic       ref_clk_in,
  input  wire logic [8:0] contact_req_in,
  output logic      [8:0] term_out
);
  // contact levels settle one cycle after the request, clean of bounce
  always @(posedge ref_clk_in) begin
    term_out <= #1 contact_req_in;
  end
endmodule
`default_nettype wire

// file: bench/run_command_selector_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fails++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module run_command_selector_tb;
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              clk_en = 1'b1;
  logic [1:0]        src = 2'h0;
  logic [1:0]        tcs = 2'h0;
  logic [62:0]       fsel;
  logic [8:0]        con = 9'h000;
  logic [8:0]        term;
  rcs_pkg::rcs_cmd_t key = '0;
  rcs_pkg::rcs_cmd_t bus = '0;
  logic              ext_stop = 1'b0;
  logic [2:0]        cmb = 3'h0;
  logic [15:0]       ref_a = 16'h012c;
  logic [15:0]       ref_b = 16'h0064;
  logic [15:0]       up_rate = 16'h0005;
  logic [15:0]       dn_rate = 16'h0003;
  logic              run, reverse_input, led, jf, jr, coast, frst;
  logic [15:0]       freq, aux;
  int                fails = 0;
  int                total_checks = 0;
  // bit map of contacts: fwd, rev, enable, jog f, coast, up, down, jog r, fault reset
  assign fsel = {rcs_pkg::FN_FRESET, rcs_pkg::FN_JOG_R, rcs_pkg::FN_DOWN, rcs_pkg::FN_UP, rcs_pkg::FN_COAST,
                 rcs_pkg::FN_JOG_F, rcs_pkg::FN_3W, rcs_pkg::FN_REV, rcs_pkg::FN_FWD};
  always #25 clk = ~clk;
  rcs_contact_model u_model (.ref_clk_in(clk), .contact_req_in(con), .term_out(term));
  rcs_run_command_selector u_dut (
    .ref_clk_in(clk), .arst_n_in(arst_n), .clk_en_in(clk_en), .run_command_source_in(src),
    .terminal_control_scheme_in(tcs), .input_terminal_function_select_in(fsel),
    .multifunction_inputs_in(term), .key_cmd_in(key), .bus_cmd_in(bus), .ext_stop_in(ext_stop),
    .reference_combine_select_in(cmb), .ref_a_in(ref_a), .ref_b_in(ref_b), .up_trim_rate_in(up_rate),
    .down_trim_rate_in(dn_rate), .trim_limit_in(16'h0014), .run_out(run), .reverse_out(reverse_input),
    .run_led_out(led), .jog_fwd_out(jf), .jog_rev_out(jr), .coast_stop_out(coast),
    .fault_reset_out(frst), .freq_ref_out(freq), .aux_ref_out(aux));
  // wait n edges, then land just after the last one
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // contacts change, then wait past the terminal latency
  task automatic press(input logic [8:0] v);
    con = v;
    tick(6);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // bounded wait for the run level
  task automatic wait_run(input logic ex);
    int i;
    for (i = 0; i < 10 && run !== ex; i++) tick(1);
    `CHK("run wait", ex, run)
    if (run !== ex) give_verdict();
  endtask
  logic [8:0] tv [8];
  logic [1:0] tr [8];
  logic [15:0] ce [6];
  initial begin
    tv = '{9'h001, 9'h003, 9'h002, 9'h000, 9'h001, 9'h003, 9'h002, 9'h000};
    tr = '{2'h2, 2'h2, 2'h3, 2'h0, 2'h2, 2'h3, 2'h0, 2'h0};
    ce = '{16'h012c, 16'h0064, 16'h0190, 16'h00c8, 16'h012c, 16'h0064};
    tick(2);
    arst_n = 1'b1;
    tick(1);
    `CHK("reset run", 1'b0, run)
    // keypad source, fieldbus ignored
    bus = 3'h4;
    tick(4);
    `CHK("bus in keypad", 1'b0, run)
    bus = 3'h0;
    key = 3'h5;
    tick(1);
    key = 3'h0;
    wait_run(1'b1);
    `CHK("run led", 1'b1, led)
    `CHK("key rev", 1'b1, reverse_input)
    key = 3'h2;
    tick(1);
    key = 3'h0;
    wait_run(1'b0);
    `CHK("led off", 1'b0, led)
    // frozen clock enable ignores the run key
    clk_en = 1'b0;
    key = 3'h4;
    tick(3);
    `CHK("frozen", 1'b0, run)
    key = 3'h0;
    clk_en = 1'b1;
    tick(2);
    `CHK("thawed", 1'b0, run)
    // fieldbus source, keypad ignored
    src = rcs_pkg::SRC_COMM;
    key = 3'h4;
    tick(4);
    `CHK("key in bus", 1'b0, run)
    key = 3'h0;
    bus = 3'h4;
    wait_run(1'b1);
    `CHK("bus fwd", 1'b0, reverse_input)
    bus = 3'h2;
    wait_run(1'b0);
    bus = 3'h0;
    src = rcs_pkg::SRC_TERMINAL;
    // two-wire level tables, first four for scheme one then scheme two
    for (int i = 0; i < 8; i++) begin
      tcs = (i < 4) ? rcs_pkg::TCS_2W1 : rcs_pkg::TCS_2W2;
      press(tv[i]);
      `CHK("2w run", tr[i][1], run)
      if (tr[i][1]) `CHK("2w dir", tr[i][0], reverse_input)
    end
    // stop from elsewhere needs a fresh activation
    tcs = rcs_pkg::TCS_2W1;
    press(9'h001);
    ext_stop = 1'b1;
    tick(3);
    ext_stop = 1'b0;
    tick(6);
    `CHK("no restart", 1'b0, run)
    press(9'h000);
    press(9'h001);
    `CHK("fresh start", 1'b1, run)
    press(9'h000);
    // three-wire one: forward edge starts, reverse toggles, enable open stops
    tcs = rcs_pkg::TCS_3W1;
    press(9'h004);
    `CHK("3w1 idle", 1'b0, run)
    press(9'h005);
    `CHK("3w1 start", 1'b1, run)
    `CHK("3w1 fwd", 1'b0, reverse_input)
    press(9'h004);
    `CHK("3w1 held", 1'b1, run)
    press(9'h006);
    `CHK("3w1 inv1", 1'b1, reverse_input)
    press(9'h004);
    `CHK("3w1 inv2", 1'b0, reverse_input)
    press(9'h000);
    `CHK("3w1 stop", 1'b0, run)
    // three-wire two: edges pick direction
    tcs = rcs_pkg::TCS_3W2;
    press(9'h004);
    press(9'h005);
    `CHK("3w2 fwd", 2'h2, {run, reverse_input})
    press(9'h007);
    `CHK("3w2 rev", 2'h3, {run, reverse_input})
    press(9'h003);
    `CHK("3w2 stop", 1'b0, run)
    // jog, coast and fault reset terminals
    press(9'h118);
    `CHK("jog coast reset", 4'hb, {jf, jr, coast, frst})
    press(9'h090);
    `CHK("jog r coast", 4'h6, {jf, jr, coast, frst})
    press(9'h000);
    // main reference combinations with no trim
    for (int m = 0; m < 6; m++) begin
      cmb = m[2:0];
      tick(4);
      `CHK("combine", ce[m], freq)
    end
    // up trim saturates at the ceiling, down returns to zero
    cmb = rcs_pkg::CMB_A;
    press(9'h020);
    tick(6);
    `CHK("aux up", 16'h0014, aux)
    con = 9'h000;
    tick(4);
    `CHK("main plus aux", 16'h0140, freq)
    press(9'h040);
    tick(10);
    `CHK("aux down", 16'h0000, aux)
    give_verdict();
  end
endmodule
`default_nettype wire

// file: hw/rcs_pkg.sv
package rcs_pkg;
  // run command sources
  localparam logic [1:0] SRC_KEYPAD   = 2'h0;
  localparam logic [1:0] SRC_TERMINAL = 2'h1;
  localparam logic [1:0] SRC_COMM     = 2'h2;
  localparam logic [1:0] SRC_RESET    = SRC_KEYPAD;
  // terminal control schemes
  localparam logic [1:0] TCS_2W1   = 2'h0;
  localparam logic [1:0] TCS_2W2   = 2'h1;
  localparam logic [1:0] TCS_3W1   = 2'h2;
  localparam logic [1:0] TCS_3W2   = 2'h3;
  localparam logic [1:0] TCS_RESET = TCS_2W1;
  // terminal function codes
  localparam logic [6:0] FN_FWD     = 7'h01;
  localparam logic [6:0] FN_REV     = 7'h02;
  localparam logic [6:0] FN_3W      = 7'h03;
  localparam logic [6:0] FN_JOG_F   = 7'h04;
  localparam logic [6:0] FN_JOG_R   = 7'h05;
  localparam logic [6:0] FN_COAST   = 7'h06;
  localparam logic [6:0] FN_FRESET  = 7'h07;
  localparam logic [6:0] FN_UP      = 7'h0a;
  localparam logic [6:0] FN_DOWN    = 7'h0b;
  localparam logic [6:0] FN_MAX     = 7'h5f;
  // reference combination modes
  localparam logic [2:0] CMB_A     = 3'h0;
  localparam logic [2:0] CMB_B     = 3'h1;
  localparam logic [2:0] CMB_ADD   = 3'h2;
  localparam logic [2:0] CMB_SUB   = 3'h3;
  localparam logic [2:0] CMB_MAX   = 3'h4;
  localparam logic [2:0] CMB_MIN   = 3'h5;
  localparam logic [2:0] CMB_RESET = CMB_A;
  // command carried by keypad and fieldbus
  typedef struct packed {
    logic run;
    logic stop;
    logic reverse_input;
  } rcs_cmd_t;
endpackage

// file: hw/rcs_run_command_selector.sv
// Contract
// R01: one run source: keypad, terminals, fieldbus
// R02: keypad run key starts, lights indicator
// R03: keypad stop key stops, clears indicator
// R04: nine terminals with function codes 0..95
// R05: terminal scheme setting 0..3, default 0
// R06: two-wire one: level table, both hold
// R07: two-wire two: forward enables, reverse direction
// R08: three-wire one: forward edge starts, reverse sets
// R09: three-wire one: reverse transitions invert direction
// R10: three-wire enable open stops drive
// R11: three-wire two: edges choose run direction
// R12: two-wire needs fresh edge after stop
// R13: fieldbus start and stop when selected
// R14: final reference is main plus trim
// R15: up/down terminals trim at own rates
// R16: main combine select modes 0..5
// R17: main channel switch while running
// R18: terminals sampled, edges from previous sample
// R19: commands from unselected sources ignored; coast stop and fault reset terminals act whatever the source
`timescale 1ns/10ps
`default_nettype none
module rcs_run_command_selector #(
  parameter int N_TERM = 9,
  parameter int FW     = 16
) (
  input  wire logic              ref_clk_in,
  input  wire logic              arst_n_in,
  input  wire logic              clk_en_in,
  input  wire logic [1:0]        run_command_source_in,
  input  wire logic [1:0]        terminal_control_scheme_in,
  input  wire logic [N_TERM*7-1:0] input_terminal_function_select_in,
  input  wire logic [N_TERM-1:0] multifunction_inputs_in,
  input  wire rcs_pkg::rcs_cmd_t key_cmd_in,
  input  wire rcs_pkg::rcs_cmd_t bus_cmd_in,
  input  wire logic              ext_stop_in,
  input  wire logic [2:0]        reference_combine_select_in,
  input  wire logic [FW-1:0]     ref_a_in,
  input  wire logic [FW-1:0]     ref_b_in,
  input  wire logic [FW-1:0]     up_trim_rate_in,
  input  wire logic [FW-1:0]     down_trim_rate_in,
  input  wire logic [FW-1:0]     trim_limit_in,
  output logic                   run_out,
  output logic                   reverse_out,
  output logic                   run_led_out,
  output logic                   jog_fwd_out,
  output logic                   jog_rev_out,
  output logic                   coast_stop_out,
  output logic                   fault_reset_out,
  output logic [FW-1:0]          freq_ref_out,
  output logic [FW-1:0]          aux_ref_out
);

  // refuse sizes the decode and arithmetic cannot serve
  if (N_TERM < 1 || N_TERM > 16) begin : g_bad_term
    $error("N_TERM out of range");
  end
  if (FW < 2 || FW > 32) begin : g_bad_width
    $error("FW out of range");
  end

  // gather terminals by function, ignoring codes beyond range
  function automatic logic fn_active(input logic [N_TERM*7-1:0] sel, input logic [N_TERM-1:0] lv,
                                     input logic [6:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < N_TERM; i++) begin
      if (sel[i*7 +: 7] == code && code <= rcs_pkg::FN_MAX) begin
        r = r | lv[i];
      end
    end
    return r;
  endfunction

  // saturating add/sub within limit
  function automatic logic [FW-1:0] sat_step(input logic [FW-1:0] v, input logic [FW-1:0] d,
                                             input logic up, input logic [FW-1:0] lim);
    logic [FW:0] s;
    s = '0;
    if (up) begin
      s = {1'b0, v} + {1'b0, d};
      return (s > {1'b0, lim}) ? lim : s[FW-1:0];
    end
    return (v > d) ? v - d : '0;
  endfunction

  logic [N_TERM-1:0] term_q;
  logic              fwd_q, rev_q, en3_q;
  logic              fwd_d, rev_d, en3_d;
  logic              fwd_rise, rev_rise, rev_edge;
  logic              run_q, dir_q;
  logic              armed_q;
  logic              t_run, t_dir, t_set;
  logic              keep;

  // sampled terminal image and previous function levels
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      term_q <= '0;
      fwd_q  <= 1'b0;
      rev_q  <= 1'b0;
      en3_q  <= 1'b0;
    end else if (clk_en_in) begin
      term_q <= multifunction_inputs_in; // [R18]
      fwd_q  <= fwd_d;
      rev_q  <= rev_d;
      en3_q  <= en3_d;
    end
  end

  // function decode and edges from sample vs previous
  always_comb begin
    fwd_d    = fn_active(input_terminal_function_select_in, term_q, rcs_pkg::FN_FWD); // [R04]
    rev_d    = fn_active(input_terminal_function_select_in, term_q, rcs_pkg::FN_REV);
    en3_d    = fn_active(input_terminal_function_select_in, term_q, rcs_pkg::FN_3W);
    fwd_rise = fwd_d & ~fwd_q; // [R18]
    rev_rise = rev_d & ~rev_q;
    rev_edge = rev_d ^ rev_q;
  end

  // terminal run decode per scheme
  always_comb begin
    t_set = 1'b1;
    t_run = run_q;
    t_dir = dir_q;
    unique case (terminal_control_scheme_in) // [R05]
      rcs_pkg::TCS_2W1: begin
        if (!fwd_d && !rev_d) begin
          t_run = 1'b0; // [R06]
        end else if (fwd_d && !rev_d) begin
          t_run = armed_q | fwd_rise; // [R12]
          t_dir = 1'b0;
        end else if (!fwd_d && rev_d) begin
          t_run = armed_q | rev_rise; // [R12]
          t_dir = 1'b1;
        end else begin
          t_set = 1'b0; // [R06]
        end
      end
      rcs_pkg::TCS_2W2: begin
        if (!fwd_d) begin
          t_run = 1'b0; // [R07]
        end else begin
          t_run = armed_q | fwd_rise; // [R12]
          t_dir = rev_d; // [R07]
        end
      end
      rcs_pkg::TCS_3W1: begin
        if (!en3_d) begin
          t_run = 1'b0; // [R10]
        end else if (fwd_rise && !run_q) begin
          t_run = 1'b1; // [R08]
          t_dir = rev_d;
        end else if (run_q && rev_edge) begin
          t_dir = ~dir_q; // [R09]
        end else begin
          t_set = 1'b0;
        end
      end
      rcs_pkg::TCS_3W2: begin
        if (!en3_d) begin
          t_run = 1'b0; // [R10]
        end else if (fwd_rise) begin
          t_run = 1'b1; // [R11]
          t_dir = 1'b0;
        end else if (rev_rise) begin
          t_run = 1'b1; // [R11]
          t_dir = 1'b1;
        end else begin
          t_set = 1'b0;
        end
      end
    endcase
    keep = ~t_set;
  end

  // two-wire re-arm: cleared by outside stop or forward and reverse both open, set while running or on a rising edge
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      armed_q <= 1'b0;
    end else if (clk_en_in) begin
      if (!fwd_d && !rev_d) begin
        armed_q <= 1'b0;
      end else if (ext_stop_in) begin
        armed_q <= 1'b0; // [R12]
      end else if (run_q || fwd_rise || rev_rise) begin
        armed_q <= 1'b1;
      end
    end
  end

  // run state from the single selected source
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_q <= 1'b0;
      dir_q <= 1'b0;
    end else if (clk_en_in) begin
      if (ext_stop_in) begin
        run_q <= 1'b0; // [R12]
      end else begin
        unique case (run_command_source_in) // [R01] [R19]
          rcs_pkg::SRC_KEYPAD: begin
            if (run_q && key_cmd_in.stop) begin
              run_q <= 1'b0; // [R03]
            end else if (key_cmd_in.run) begin
              run_q <= 1'b1; // [R02]
              dir_q <= key_cmd_in.reverse_input;
            end
          end
          rcs_pkg::SRC_TERMINAL: begin
            if (!keep) begin
              run_q <= t_run;
              dir_q <= t_dir;
            end
          end
          rcs_pkg::SRC_COMM: begin
            if (bus_cmd_in.stop) begin
              run_q <= 1'b0; // [R13]
            end else if (bus_cmd_in.run) begin
              run_q <= 1'b1; // [R13]
              dir_q <= bus_cmd_in.reverse_input;
            end
          end
          default: begin
            run_q <= run_q;
          end
        endcase
      end
    end
  end

  // registered run, direction, indicator and terminal side functions
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_out         <= 1'b0;
      reverse_out     <= 1'b0;
      run_led_out     <= 1'b0;
      jog_fwd_out     <= 1'b0;
      jog_rev_out     <= 1'b0;
      coast_stop_out  <= 1'b0;
      fault_reset_out <= 1'b0;
    end else if (clk_en_in) begin
      run_out         <= run_q;
      reverse_out     <= dir_q;
      run_led_out     <= run_q; // [R02] [R03]
      jog_fwd_out     <= (run_command_source_in == rcs_pkg::SRC_TERMINAL) &
                         fn_active(input_terminal_function_select_in, term_q, rcs_pkg::FN_JOG_F); // [R19]
      jog_rev_out     <= (run_command_source_in == rcs_pkg::SRC_TERMINAL) &
                         fn_active(input_terminal_function_select_in, term_q, rcs_pkg::FN_JOG_R);
      coast_stop_out  <= fn_active(input_terminal_function_select_in, term_q, rcs_pkg::FN_COAST);
      fault_reset_out <= fn_active(input_terminal_function_select_in, term_q, rcs_pkg::FN_FRESET);
    end
  end

  logic          up_d, dn_d;
  logic [FW-1:0] main_d;
  logic [FW:0]   sum_d;

  // main reference combination, live switching of channels
  always_comb begin
    up_d   = fn_active(input_terminal_function_select_in, term_q, rcs_pkg::FN_UP);
    dn_d   = fn_active(input_terminal_function_select_in, term_q, rcs_pkg::FN_DOWN);
    main_d = ref_a_in;
    unique case (reference_combine_select_in) // [R16] [R17]
      rcs_pkg::CMB_A:   main_d = ref_a_in;
      rcs_pkg::CMB_B:   main_d = ref_b_in;
      rcs_pkg::CMB_ADD: main_d = sat_step(ref_a_in, ref_b_in, 1'b1, '1);
      rcs_pkg::CMB_SUB: main_d = sat_step(ref_a_in, ref_b_in, 1'b0, '1);
      rcs_pkg::CMB_MAX: main_d = (ref_a_in > ref_b_in) ? ref_a_in : ref_b_in;
      rcs_pkg::CMB_MIN: main_d = (ref_a_in < ref_b_in) ? ref_a_in : ref_b_in;
      default:          main_d = ref_a_in;
    endcase
    sum_d = {1'b0, main_d} + {1'b0, aux_ref_out};
  end

  // auxiliary trim and final reference
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aux_ref_out  <= '0;
      freq_ref_out <= '0;
    end else if (clk_en_in) begin
      if (up_d && !dn_d) begin
        aux_ref_out <= sat_step(aux_ref_out, up_trim_rate_in, 1'b1, trim_limit_in); // [R15]
      end else if (dn_d && !up_d) begin
        aux_ref_out <= sat_step(aux_ref_out, down_trim_rate_in, 1'b0, trim_limit_in); // [R15]
      end
      freq_ref_out <= sum_d[FW] ? '1 : sum_d[FW-1:0]; // [R14]
    end
  end

  // keypad stop while running clears run on the next edge, the indicator one edge later
  a_key_stop: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R03]
    (clk_en_in && run_command_source_in == rcs_pkg::SRC_KEYPAD && run_q && key_cmd_in.stop)
    |=> (!run_q and (clk_en_in |=> !run_led_out)))
    else $error("keypad stop not honoured");

  a_key_run: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R02]
    (clk_en_in && run_command_source_in == rcs_pkg::SRC_KEYPAD && !ext_stop_in && key_cmd_in.run
     && !(run_q && key_cmd_in.stop)) |=> run_q)
    else $error("keypad run not honoured");

  a_3w_enable_open: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R10]
    (clk_en_in && run_command_source_in == rcs_pkg::SRC_TERMINAL && terminal_control_scheme_in[1]
     && !en3_d) |=> !run_q)
    else $error("three-wire enable open did not stop");

  a_3w1_reverse: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R09]
    (clk_en_in && !ext_stop_in && run_command_source_in == rcs_pkg::SRC_TERMINAL
     && terminal_control_scheme_in == rcs_pkg::TCS_3W1 && en3_d && run_q && !fwd_rise && rev_edge)
    |=> dir_q != $past(dir_q))
    else $error("direction not inverted");

  a_2w2_stop: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R07]
    (clk_en_in && run_command_source_in == rcs_pkg::SRC_TERMINAL
     && terminal_control_scheme_in == rcs_pkg::TCS_2W2 && !fwd_d) |=> !run_q)
    else $error("two-wire two did not stop");

  a_2w1_hold: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R06]
    (clk_en_in && !ext_stop_in && run_command_source_in == rcs_pkg::SRC_TERMINAL
     && terminal_control_scheme_in == rcs_pkg::TCS_2W1 && fwd_d && rev_d) |=> $stable(run_q))
    else $error("two-wire one hold broken");

  a_no_restart: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R12]
    (clk_en_in && ext_stop_in) ##1 (clk_en_in && !ext_stop_in && !fwd_rise && !rev_rise
     && run_command_source_in == rcs_pkg::SRC_TERMINAL && !terminal_control_scheme_in[1]) |=> !run_q)
    else $error("two-wire restarted without fresh edge");

  a_comm_ignore: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R19]
    (clk_en_in && run_command_source_in == rcs_pkg::SRC_COMM && !bus_cmd_in.run && !run_q)
    |=> !run_q)
    else $error("run from unselected source");

  a_comm_stop: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R13]
    (clk_en_in && run_command_source_in == rcs_pkg::SRC_COMM && bus_cmd_in.stop)
    |=> (!run_q and (clk_en_in |=> !run_out)))
    else $error("fieldbus stop not honoured");

  // three-wire two: a rising edge picks run and direction, forward winning when both rise
  a_3w2_fwd_edge: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R11]
    (clk_en_in && !ext_stop_in && run_command_source_in == rcs_pkg::SRC_TERMINAL
     && terminal_control_scheme_in == rcs_pkg::TCS_3W2 && en3_d && fwd_rise) |=> (run_q && !dir_q))
    else $error("three-wire two forward edge ignored");

  a_3w2_rev_edge: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in) // [R11]
    (clk_en_in && !ext_stop_in && run_command_source_in == rcs_pkg::SRC_TERMINAL
     && terminal_control_scheme_in == rcs_pkg::TCS_3W2 && en3_d && rev_rise && !fwd_rise) |=> (run_q && dir_q))
    else $error("three-wire two reverse edge ignored");

endmodule
`default_nettype wire
